// [design/crs_pkg.sv]
// Purpose: Shared constants and types for channel range and scan control
// Assumes: Single 40 MHz clock, plain register port
// Notes:   Offsets are byte addresses on the plain port
package crs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CRS_ADDR_MODE   = 8'h00; // Bit0 auto-scan, bits 6:4 manual channel
  localparam logic [7:0] CRS_ADDR_SCANEN = 8'h04; // Auto-scan channel enables
  localparam logic [7:0] CRS_ADDR_STATUS = 8'h08; // Current channel, reference source
  localparam logic [7:0] CRS_ADDR_RANGE0 = 8'h10; // Range codes, one word per channel
  localparam logic [7:0] CRS_RANGE_STEP  = 8'h04;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         CRS_MODE_AUTO_BIT = 0;
  localparam int         CRS_MODE_CH_LSB   = 4;
  localparam int         CRS_STAT_REF_BIT  = 8;
  localparam int         CRS_RANGE_W       = 4;
  localparam logic [3:0] CRS_RANGE_RST     = 4'h0;

  // ****************************************
  // Range codes
  // ****************************************
  localparam logic [3:0] CRS_BIP_2P5    = 4'h0;
  localparam logic [3:0] CRS_BIP_1P25   = 4'h1;
  localparam logic [3:0] CRS_BIP_0P625  = 4'h2;
  localparam logic [3:0] CRS_BIP_0P3125 = 4'h3;
  localparam logic [3:0] CRS_BIP_0P156  = 4'hB;
  localparam logic [3:0] CRS_UNI_2P5    = 4'h5;
  localparam logic [3:0] CRS_UNI_1P25   = 4'h6;
  localparam logic [3:0] CRS_UNI_0P625  = 4'h7;
  localparam logic [3:0] CRS_UNI_0P3125 = 4'hF;

  // Gain step: 0 is x2.5 span, 4 is x0.15625 span
  typedef struct packed {
    logic       unipolar;
    logic [2:0] gainStep;
    logic       valid;
  } crs_gain_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } crs_req_t;

endpackage

// [design/crs_top.sv]
// Purpose: Per-channel range codes, mux steering and reference selection
// Assumes: Chip-select arrives synchronous to ref_clk, active low
// Notes:   Gain and mux outputs are registered; range latches at frame start
`timescale 1ns/1ps
module crs_top
  import crs_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // Register port
  input  wire crs_req_t                regReq,
  output logic [31:0]                  regRdata,
  // Frame and strap
  input  wire logic                    csN,
  input  wire logic                    referenceSourceStrap,
  // Analog steering and scan count
  output logic [$clog2(NUM_CH)-1:0]    muxChannel,
  output crs_gain_t                    gainSetting,
  output logic                         internalRefEnable,
  output logic                         referenceInOutPinOe,
  output logic [7:0]                   scanCount
);

  localparam int CW = $clog2(NUM_CH);

  // Elaboration guard: the mux and the register map serve 4 or 8 inputs only
  if (NUM_CH != 4 && NUM_CH != 8) begin : g_badChannelCount
    $error("NUM_CH must be 4 or 8");
  end

  // ****************************************
  // State
  // ****************************************
  logic [CRS_RANGE_W-1:0] channelRangeCode [NUM_CH];
  logic                   autoScan;
  logic [CW-1:0]          manualChannelSelectCmd;
  logic [NUM_CH-1:0]      scanEnable;
  logic                   csPrev;
  logic                   csFall;
  logic [CW-1:0]          next_channel;
  logic [CW-1:0]          frameChannel;
  logic [7:0]             next_count;
  crs_gain_t              next_gain;

  assign csFall = csPrev & ~csN;

  // Chip-select history for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csPrev <= 1'b1;
    end else begin
      csPrev <= csN;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channelRangeCode[i] <= CRS_RANGE_RST;
      end
      autoScan               <= 1'b0;
      manualChannelSelectCmd <= '0;
      scanEnable             <= '1;
    end else if (regReq.wr) begin
      if (regReq.addr == CRS_ADDR_MODE) begin
        autoScan               <= regReq.wdata[CRS_MODE_AUTO_BIT];
        manualChannelSelectCmd <= regReq.wdata[CRS_MODE_CH_LSB +: CW];
      end
      if (regReq.addr == CRS_ADDR_SCANEN) begin
        scanEnable <= regReq.wdata[NUM_CH-1:0];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (regReq.addr == CRS_ADDR_RANGE0 + 8'(i) * CRS_RANGE_STEP) begin
          channelRangeCode[i] <= regReq.wdata[CRS_RANGE_W-1:0];
        end
      end
    end
  end

  // ****************************************
  // Channel sequencing
  // ****************************************
  // Next enabled channel above the current one, wrapping; stays put if none enabled
  always_comb begin
    next_channel = muxChannel;
    for (int k = NUM_CH - 1; k >= 1; k--) begin
      if (scanEnable[CW'((int'(muxChannel) + k) % NUM_CH)]) begin
        next_channel = CW'((int'(muxChannel) + k) % NUM_CH);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      muxChannel <= '0;
    end else if (!autoScan) begin
      muxChannel <= manualChannelSelectCmd;
    end else if (csFall) begin
      muxChannel <= next_channel;
    end
  end

  // Enabled channel count in auto-scan, 1 in manual; host divides 500 kSPS by it for per-channel rate
  always_comb begin
    next_count = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      next_count = next_count + 8'(scanEnable[i]);
    end
    if (!autoScan) begin
      next_count = 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scanCount <= 8'h01;
    end else begin
      scanCount <= next_count;
    end
  end

  // ****************************************
  // Gain decode
  // ****************************************
  // Latched only when a frame starts, so a mid-conversion write cannot disturb it
  always_comb begin
    next_gain = '{unipolar: 1'b0, gainStep: 3'h0, valid: 1'b1};
    unique case (channelRangeCode[frameChannel])
      CRS_BIP_2P5:    next_gain.gainStep = 3'h0;
      CRS_BIP_1P25:   next_gain.gainStep = 3'h1;
      CRS_BIP_0P625:  next_gain.gainStep = 3'h2;
      CRS_BIP_0P3125: next_gain.gainStep = 3'h3;
      CRS_BIP_0P156:  next_gain.gainStep = 3'h4;
      CRS_UNI_2P5:    next_gain = '{1'b1, 3'h0, 1'b1};
      CRS_UNI_1P25:   next_gain = '{1'b1, 3'h1, 1'b1};
      CRS_UNI_0P625:  next_gain = '{1'b1, 3'h2, 1'b1};
      CRS_UNI_0P3125: next_gain = '{1'b1, 3'h3, 1'b1};
      default:        next_gain.valid = 1'b0; // Reserved code: keep widest span
    endcase
  end

  // Channel whose frame is about to begin; a net so the checks see sampled values
  assign frameChannel = autoScan ? next_channel : manualChannelSelectCmd;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gainSetting <= '{unipolar: 1'b0, gainStep: 3'h0, valid: 1'b1};
    end else if (csFall) begin
      gainSetting <= next_gain;
    end
  end

  // ****************************************
  // Reference selection
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      internalRefEnable   <= 1'b0;
      referenceInOutPinOe <= 1'b0;
    end else begin
      internalRefEnable   <= ~referenceSourceStrap;
      referenceInOutPinOe <= ~referenceSourceStrap;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= '0;
      if (regReq.rd) begin
        if (regReq.addr == CRS_ADDR_MODE) begin
          regRdata[CRS_MODE_AUTO_BIT]           <= autoScan;
          regRdata[CRS_MODE_CH_LSB +: CW]       <= manualChannelSelectCmd;
        end
        if (regReq.addr == CRS_ADDR_SCANEN) begin
          regRdata[NUM_CH-1:0] <= scanEnable;
        end
        if (regReq.addr == CRS_ADDR_STATUS) begin
          regRdata[CW-1:0]             <= muxChannel;
          regRdata[CRS_STAT_REF_BIT]   <= referenceSourceStrap;
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (regReq.addr == CRS_ADDR_RANGE0 + 8'(i) * CRS_RANGE_STEP) begin
            regRdata[CRS_RANGE_W-1:0] <= channelRangeCode[i];
          end
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_frameStart;
    $fell(csN);
  endsequence

  chk_range_reset_zero: assert property (@(posedge ref_clk)
    $fell(rst) |-> channelRangeCode[0] == CRS_RANGE_RST)
    else $error("range code not zero after reset");

  chk_range_write_stores: assert property (@(posedge ref_clk) disable iff (rst)
    regReq.wr && regReq.addr == CRS_ADDR_RANGE0
    |=> channelRangeCode[0] == $past(regReq.wdata[3:0]))
    else $error("range write not stored");

  chk_manual_follow: assert property (@(posedge ref_clk) disable iff (rst)
    !autoScan && !$past(regReq.wr) |-> ##1 muxChannel == $past(manualChannelSelectCmd))
    else $error("manual channel not followed");

  chk_auto_step: assert property (@(posedge ref_clk) disable iff (rst)
    autoScan ##0 s_frameStart |=> muxChannel == $past(next_channel))
    else $error("auto-scan did not step");

  chk_auto_hold: assert property (@(posedge ref_clk) disable iff (rst)
    autoScan && $past(autoScan) && !csFall |=> muxChannel == $past(muxChannel))
    else $error("auto-scan stepped without frame");

  chk_scan_enabled: assert property (@(posedge ref_clk) disable iff (rst)
    autoScan && csFall && |scanEnable |=> scanEnable[muxChannel])
    else $error("disabled channel visited");

  chk_gain_stable: assert property (@(posedge ref_clk) disable iff (rst)
    !csFall |=> $stable(gainSetting))
    else $error("gain changed mid-frame");

  chk_bip_decode: assert property (@(posedge ref_clk) disable iff (rst)
    csFall && channelRangeCode[frameChannel] == CRS_BIP_0P156
    |=> !gainSetting.unipolar && gainSetting.gainStep == 3'h4)
    else $error("bipolar decode wrong");

  chk_uni_decode: assert property (@(posedge ref_clk) disable iff (rst)
    csFall && channelRangeCode[frameChannel] == CRS_UNI_0P3125
    |=> gainSetting.unipolar && gainSetting.gainStep == 3'h3)
    else $error("unipolar decode wrong");

  chk_ref_internal: assert property (@(posedge ref_clk) disable iff (rst)
    !referenceSourceStrap |=> internalRefEnable && referenceInOutPinOe)
    else $error("internal reference not driven");

  chk_ref_external: assert property (@(posedge ref_clk) disable iff (rst)
    referenceSourceStrap |=> !referenceInOutPinOe)
    else $error("reference pin driven in external mode");

  chk_scan_count: assert property (@(posedge ref_clk) disable iff (rst)
    autoScan |=> scanCount == 8'($countones($past(scanEnable))))
    else $error("scan count wrong");

  // Register traffic shapes used by the checks below
  sequence s_rangeWrite0;
    regReq.wr && regReq.addr == CRS_ADDR_RANGE0;
  endsequence

  sequence s_statusRead;
    regReq.rd && regReq.addr == CRS_ADDR_STATUS;
  endsequence

  // Top channel word, so a stuck address decode on the far end shows up
  localparam logic [7:0] RANGE_LAST_ADDR = CRS_ADDR_RANGE0 + 8'(NUM_CH - 1) * CRS_RANGE_STEP;

  // Range storage: per channel, separate, readable
  chk_range_independent: assert property (@(posedge ref_clk) disable iff (rst)
    s_rangeWrite0 |=> $stable(channelRangeCode[1]))
    else $error("range write leaked to another channel");

  chk_range_write_last: assert property (@(posedge ref_clk) disable iff (rst)
    regReq.wr && regReq.addr == RANGE_LAST_ADDR
    |=> channelRangeCode[NUM_CH-1] == $past(regReq.wdata[CRS_RANGE_W-1:0]))
    else $error("top channel range write not stored");

  chk_range_readback: assert property (@(posedge ref_clk) disable iff (rst)
    regReq.rd && regReq.addr == CRS_ADDR_RANGE0
    |=> regRdata[CRS_RANGE_W-1:0] == $past(channelRangeCode[0]))
    else $error("range read back wrong");

  // Power-on state: widest bipolar span everywhere
  chk_reset_gain: assert property (@(posedge ref_clk)
    $fell(rst) |-> gainSetting.valid && !gainSetting.unipolar && gainSetting.gainStep == 3'h0)
    else $error("gain not widest after reset");

  chk_range_reset_last: assert property (@(posedge ref_clk)
    $fell(rst) |-> channelRangeCode[NUM_CH-1] == CRS_RANGE_RST)
    else $error("top channel range not zero after reset");

  // Widest spans of both polarities and the legal step ranges
  chk_bip_widest: assert property (@(posedge ref_clk) disable iff (rst)
    csFall && channelRangeCode[frameChannel] == CRS_BIP_2P5
    |=> gainSetting.valid && !gainSetting.unipolar && gainSetting.gainStep == 3'h0)
    else $error("widest bipolar decode wrong");

  chk_uni_widest: assert property (@(posedge ref_clk) disable iff (rst)
    csFall && channelRangeCode[frameChannel] == CRS_UNI_2P5
    |=> gainSetting.valid && gainSetting.unipolar && gainSetting.gainStep == 3'h0)
    else $error("widest unipolar decode wrong");

  chk_bip_step_range: assert property (@(posedge ref_clk) disable iff (rst)
    gainSetting.valid && !gainSetting.unipolar |-> gainSetting.gainStep <= 3'h4)
    else $error("bipolar gain step out of range");

  chk_uni_step_range: assert property (@(posedge ref_clk) disable iff (rst)
    gainSetting.unipolar |-> gainSetting.valid && gainSetting.gainStep <= 3'h3)
    else $error("unipolar gain step out of range");

  // Channel steering as software sees it
  chk_status_channel: assert property (@(posedge ref_clk) disable iff (rst)
    s_statusRead |=> regRdata[CW-1:0] == $past(muxChannel))
    else $error("status channel wrong");

  chk_scan_adjacent: assert property (@(posedge ref_clk) disable iff (rst)
    autoScan && csFall && scanEnable[CW'(muxChannel + 1'b1)]
    |=> muxChannel == CW'($past(muxChannel) + 1'b1))
    else $error("auto-scan skipped an enabled channel");

  chk_manual_count: assert property (@(posedge ref_clk) disable iff (rst)
    !autoScan |=> scanCount == 8'h01)
    else $error("manual scan count not one");

  // Internal reference off in external mode, and its report
  chk_ref_external_off: assert property (@(posedge ref_clk) disable iff (rst)
    referenceSourceStrap |=> !internalRefEnable)
    else $error("internal reference on in external mode");

  chk_status_strap: assert property (@(posedge ref_clk) disable iff (rst)
    s_statusRead |=> regRdata[CRS_STAT_REF_BIT] == $past(referenceSourceStrap))
    else $error("status strap bit wrong");

endmodule

// [verif/crs_host_model.sv]
// Purpose: Host-side model that frames conversions with chip-select
// Assumes: One frame is requested at a time
// Notes:   Chip-select idles high between frames and after reset
`timescale 1ns/1ps
module crs_host_model #(
  parameter int FRAME = 6
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Control from the bench
  input  wire logic frameGo,
  input  wire logic strap,
  // Far side pins
  output logic      csN,
  output logic      frameDone,
  output logic      extRefOn
);
  logic [7:0] cnt;

  // Hold csN low for FRAME cycles; a request mid-frame is ignored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csN <= 1'b1;
      cnt <= 8'h00;
    end else if (frameGo && csN) begin
      csN <= 1'b0;
      cnt <= 8'(FRAME);
    end else if (!csN) begin
      cnt <= cnt - 8'h01;
      csN <= (cnt == 8'h01);
    end
  end
  assign frameDone = csN;
  // Outside reference is driven only while the strap selects it
  assign extRefOn = strap;
endmodule

// [verif/crs_top_tb.sv]
// Purpose: Self-checking bench for range codes, scanning and reference pins
// Assumes: Eight channels, host model frames the conversions
// Notes:   Random codes and the first scan mask come from a fixed-seed shift register
`timescale 1ns/1ps
module crs_top_tb;
  import crs_pkg::*;
  logic        ref_clk, rst, csN, strap, frameGo, frameDone, extRefOn;
  logic        internalRefEnable, referenceInOutPinOe;
  crs_req_t    regReq;
  crs_gain_t   gainSetting;
  logic [31:0] regRdata, rdv;
  logic [2:0]  muxChannel, expCh;
  logic [7:0]  scanCount, mask;
  logic [3:0]  codes [8];
  logic [16:0] lfsrState;
  int          n_mismatch, num_checks, cyc;

  crs_top #(.NUM_CH(8)) uut (.ref_clk(ref_clk), .rst(rst), .regReq(regReq),
    .regRdata(regRdata), .csN(csN), .referenceSourceStrap(strap),
    .muxChannel(muxChannel), .gainSetting(gainSetting),
    .internalRefEnable(internalRefEnable),
    .referenceInOutPinOe(referenceInOutPinOe), .scanCount(scanCount));
  crs_host_model #(.FRAME(6)) host (.ref_clk(ref_clk), .rst(rst),
    .frameGo(frameGo), .strap(strap), .csN(csN), .frameDone(frameDone),
    .extRefOn(extRefOn));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // Expected gain for a range code; reserved codes give valid low with the widest bipolar span
  function automatic crs_gain_t expGain(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return '{1'b0, 3'(c), 1'b1};
      4'hB: return '{1'b0, 3'h4, 1'b1};
      4'h5, 4'h6, 4'h7: return '{1'b1, 3'(c - 4'h5), 1'b1};
      4'hF: return '{1'b1, 3'h3, 1'b1};
      default: return '{1'b0, 3'h0, 1'b0};
    endcase
  endfunction
  // Next enabled channel above c, wrapping; holds when none is enabled
  function automatic logic [2:0] nextEn(input logic [2:0] c, input logic [7:0] m);
    logic [2:0] n;
    n = c;
    for (int i = 0; i < 8; i++) begin
      n = n + 3'h1;
      if (m[n]) return n;
    end
    return c;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic checkGain(input logic [3:0] c);
    crs_gain_t e;
    e = expGain(c);
    check(32'(gainSetting & (e.valid ? 5'h1F : 5'h01)), 32'(e));
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic frame();
    @(posedge ref_clk);
    frameGo <= 1'b1;
    @(posedge ref_clk);
    frameGo <= 1'b0;
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      if (frameDone) break;
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Clock at 40 MHz
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    regReq = '0;
    strap = 1'b0;
    frameGo = 1'b0;
    lfsrState = 17'h12683;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(32'(gainSetting), 32'(crs_gain_t'{1'b0, 3'h0, 1'b1}));
    check(32'(internalRefEnable & referenceInOutPinOe), 32'h1);
    for (int i = 0; i < 8; i++) begin
      regRead(CRS_ADDR_RANGE0 + 8'(i) * CRS_RANGE_STEP, rdv);
      check(rdv & 32'hF, 32'h0);
    end
    regRead(8'hFC, rdv);
    check(rdv, 32'h0);
    $display("Test reset done");
    // Every code on channel 0, applied at the next frame
    for (int c = 0; c < 16; c++) begin
      regWrite(CRS_ADDR_RANGE0, 32'(c));
      frame();
      checkGain(4'(c));
    end
    // Range write inside a frame waits for the next one
    regWrite(CRS_ADDR_RANGE0, 32'h5);
    frame();
    fork
      frame();
      begin
        repeat (3) @(posedge ref_clk);
        regWrite(CRS_ADDR_RANGE0, 32'hF);
      end
    join
    checkGain(4'h5);
    frame();
    checkGain(4'hF);
    $display("Test decode done");
    // Independent random codes, then manual selection of each channel
    for (int i = 0; i < 8; i++) begin
      lfsrState = lfsr(lfsrState);
      codes[i] = lfsrState[3:0];
      regWrite(CRS_ADDR_RANGE0 + 8'(i) * CRS_RANGE_STEP, 32'(codes[i]));
    end
    for (int i = 7; i >= 0; i--) begin
      regWrite(CRS_ADDR_MODE, 32'(i) << CRS_MODE_CH_LSB);
      frame();
      check(32'(muxChannel), 32'(i));
      checkGain(codes[i]);
      check(32'(scanCount), 32'h1);
      regRead(CRS_ADDR_STATUS, rdv);
      check(rdv & 32'h7, 32'(i));
    end
    $display("Test manual done");
    // Auto scan with a random mask, then a single top channel
    lfsrState = lfsr(lfsrState);
    for (int p = 0; p < 2; p++) begin
      mask = (p == 0) ? (lfsrState[7:0] | 8'h01) : 8'h80;
      regWrite(CRS_ADDR_SCANEN, 32'(mask));
      regWrite(CRS_ADDR_MODE, 32'h0);
      regWrite(CRS_ADDR_MODE, 32'h1);
      expCh = 3'h0;
      for (int k = 0; k < 12; k++) begin
        frame();
        expCh = nextEn(expCh, mask);
        check(32'(muxChannel), 32'(expCh));
        checkGain(codes[expCh]);
        check(32'(scanCount), 32'($countones(mask)));
      end
    end
    $display("Test auto done");
    // Reference strap both ways
    @(posedge ref_clk);
    strap <= 1'b1;
    regRead(CRS_ADDR_STATUS, rdv);
    check(rdv >> CRS_STAT_REF_BIT & 32'h1, 32'h1);
    check(32'(internalRefEnable | referenceInOutPinOe), 32'h0);
    check(32'(referenceInOutPinOe & extRefOn), 32'h0);
    @(posedge ref_clk);
    strap <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'(internalRefEnable & referenceInOutPinOe), 32'h1);
    $display("Test reference done");
    // Reset in mid-run brings a narrowed channel back to the widest span
    regWrite(CRS_ADDR_RANGE0, 32'hF);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    regRead(CRS_ADDR_RANGE0, rdv);
    check(rdv & 32'hF, 32'h0);
    check(32'(gainSetting), 32'(crs_gain_t'{1'b0, 3'h0, 1'b1}));
    $display("Test reset again done");
    complete_run();
  end
endmodule
